// file: design/rff_filter.sv
`timescale 1ns/1ps
`include "rff_regs.svh"

module rff_filter (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Frame report
  input  wire logic              frame_done,
  input  wire rff_pkg::rff_frame_s frame,
  // Decision
  output rff_pkg::rff_dec_s      dec
);
  import rff_pkg::*;

  // ==========================================
  // State
  rff_state_s st;
  rff_state_s next_st;

  logic       err;
  logic       is_short;
  logic       is_long;
  logic       mof_cap;
  logic       mof_eff;
  logic       hit;
  logic       filtered;
  logic       match;
  logic       class_ok;
  logic       type_ok;
  logic       take;
  logic       deliver;
  logic       inc_sof;
  logic       inc_mof;
  logic       inc_dma;
  logic       clr_sof;
  logic       clr_mof;
  logic       clr_dma;
  rff_class_e cls;

  assign reg_rdata = st.rdata;
  assign dec       = st.dec;

  // ==========================================
  // Classification and decision
  always_comb begin
    err      = frame.crc_err | frame.code_err | frame.align_err;
    is_short = frame.len < `RFF_MIN_LEN;
    is_long  = frame.len > st.rx_max_length;
    // Overrun at or past the maximum is really a truncated long frame
    mof_cap  = frame.mof_ovr & (frame.len >= st.rx_max_length);
    mof_eff  = frame.mof_ovr & ~mof_cap;
    hit      = frame.addr_hit & frame.chan_en;
    filtered = hit & ~frame.match_or_filter_bit;
    match    = hit & frame.match_or_filter_bit
             & (~frame.ctrl | st.control_frame_enable);
    if (is_short) begin
      cls = err ? RFF_FRAG : RFF_UNDER;
    end else if (is_long | mof_cap) begin
      cls = err ? RFF_JABBER : RFF_OVER;
    end else begin
      cls = err ? RFF_ERRORED : RFF_PROPER;
    end
    // Enables select classes; the control enable also gates the match result
    case (cls)
      RFF_PROPER:  class_ok = 1'b1;
      RFF_UNDER:   class_ok = st.short_frame_enable;
      RFF_FRAG:    class_ok = st.short_frame_enable & st.error_frame_enable;
      default:     class_ok = st.error_frame_enable;
    endcase
    type_ok = class_ok & (~frame.ctrl | st.control_frame_enable);
    take    = match | st.accept_all_enable;
    if (frame.sof_ovr) begin
      deliver = 1'b0;
    end else if (mof_eff) begin
      deliver = ~filtered & take & st.error_frame_enable;
    end else begin
      deliver = ~filtered & take & type_ok;
    end
    inc_sof = frame_done & frame.sof_ovr;
    inc_mof = frame_done & ~frame.sof_ovr & mof_eff;
    inc_dma = frame_done & frame.ovr_dma & (frame.sof_ovr | mof_eff);
    clr_sof = reg_wr & (reg_addr == `RFF_ADDR_SOF_CNT);
    clr_mof = reg_wr & (reg_addr == `RFF_ADDR_MOF_CNT);
    clr_dma = reg_wr & (reg_addr == `RFF_ADDR_DMA_CNT);
  end

  // ==========================================
  // Next state
  always_comb begin
    next_st = st;
    // Decision
    next_st.dec.valid         = frame_done;
    next_st.dec.deliver       = frame_done & deliver;
    next_st.dec.overrun       = frame_done & deliver & mof_eff;
    next_st.dec.no_match_flag = frame_done & deliver & ~match;
    next_st.dec.truncate      = frame_done & (is_long | mof_cap);
    // Channel and class hold until the next report
    if (frame_done) begin
      next_st.dec.chan = match ? frame.hit_chan : st.promiscuous_channel_select;
      next_st.dec.cls  = cls;
    end
    // Counters: a write clears, a same-cycle event still counts
    next_st.sof_overrun_counter = (clr_sof ? `RFF_CNT_RST : st.sof_overrun_counter)
                                + (inc_sof ? `RFF_CNT_ONE : `RFF_CNT_RST);
    next_st.mof_overrun_counter = (clr_mof ? `RFF_CNT_RST : st.mof_overrun_counter)
                                + (inc_mof ? `RFF_CNT_ONE : `RFF_CNT_RST);
    next_st.dma_overrun_counter = (clr_dma ? `RFF_CNT_RST : st.dma_overrun_counter)
                                + (inc_dma ? `RFF_CNT_ONE : `RFF_CNT_RST);
    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        `RFF_ADDR_FILTER_EN: begin
          next_st.accept_all_enable    = reg_wdata[`RFF_BIT_ACCEPT_ALL];
          next_st.error_frame_enable   = reg_wdata[`RFF_BIT_ERROR];
          next_st.control_frame_enable = reg_wdata[`RFF_BIT_CONTROL];
          next_st.short_frame_enable   = reg_wdata[`RFF_BIT_SHORT];
          next_st.promiscuous_channel_select = reg_wdata[`RFF_CHAN_MSB:`RFF_CHAN_LSB];
        end
        `RFF_ADDR_MAX_LEN: begin
          next_st.rx_max_length = reg_wdata[15:0];
        end
        default: begin
          next_st.rx_max_length = st.rx_max_length;
        end
      endcase
    end
    // Register reads, zero outside the answer cycle
    next_st.rdata = 32'h0000_0000;
    if (reg_rd) begin
      case (reg_addr)
        `RFF_ADDR_FILTER_EN: begin
          next_st.rdata[`RFF_BIT_ACCEPT_ALL] = st.accept_all_enable;
          next_st.rdata[`RFF_BIT_ERROR]      = st.error_frame_enable;
          next_st.rdata[`RFF_BIT_CONTROL]    = st.control_frame_enable;
          next_st.rdata[`RFF_BIT_SHORT]      = st.short_frame_enable;
          next_st.rdata[`RFF_CHAN_MSB:`RFF_CHAN_LSB] = st.promiscuous_channel_select;
        end
        `RFF_ADDR_MAX_LEN: next_st.rdata[15:0] = st.rx_max_length;
        `RFF_ADDR_SOF_CNT: next_st.rdata = st.sof_overrun_counter;
        `RFF_ADDR_MOF_CNT: next_st.rdata = st.mof_overrun_counter;
        `RFF_ADDR_DMA_CNT: next_st.rdata = st.dma_overrun_counter;
        `RFF_ADDR_LAST:    next_st.rdata[$bits(rff_dec_s)-1:0] = st.dec;
        default:           next_st.rdata = 32'h0000_0000;
      endcase
    end
    // Synchronous reset
    if (srst) begin
      next_st               = '0;
      next_st.rx_max_length = `RFF_MAX_LEN_RST;
      next_st.dec.cls       = RFF_PROPER;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge core_clk) begin
    st <= next_st;
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  logic clean_in;
  logic in_err;
  logic in_mid;
  assign clean_in = frame_done & ~frame.sof_ovr & ~frame.mof_ovr;
  assign in_err   = frame.crc_err | frame.code_err | frame.align_err;
  assign in_mid   = (frame.len >= `RFF_MIN_LEN) & (frame.len <= st.rx_max_length);

  property p_filter_bit;
    frame_done & frame.addr_hit & frame.chan_en & ~frame.match_or_filter_bit
      |=> dec.valid & ~dec.deliver;
  endproperty
  a_filter_bit: assert property (p_filter_bit)
    else $error("filtered address entry was delivered");

  property p_no_accept_all;
    frame_done & ~frame.addr_hit & ~st.accept_all_enable |=> ~dec.deliver;
  endproperty
  a_no_accept_all: assert property (p_no_accept_all)
    else $error("non-matching frame delivered without accept-all");

  property p_prom_proper;
    clean_in & ~frame.addr_hit & st.accept_all_enable & ~frame.ctrl
      & ~frame.crc_err & ~frame.code_err & ~frame.align_err
      & (frame.len >= `RFF_MIN_LEN) & (frame.len <= st.rx_max_length)
      |=> dec.deliver & dec.no_match_flag
          & (dec.chan == $past(st.promiscuous_channel_select));
  endproperty
  a_prom_proper: assert property (p_prom_proper)
    else $error("proper non-matching frame not sent to promiscuous channel");

  property p_short_gate;
    clean_in & ~st.short_frame_enable & (frame.len < `RFF_MIN_LEN) |=> ~dec.deliver;
  endproperty
  a_short_gate: assert property (p_short_gate)
    else $error("short frame delivered with short enable clear");

  property p_ctrl_gate;
    clean_in & frame.ctrl & ~st.control_frame_enable |=> ~dec.deliver;
  endproperty
  a_ctrl_gate: assert property (p_ctrl_gate)
    else $error("control frame delivered with control enable clear");

  property p_sof_drop;
    frame_done & frame.sof_ovr & ~clr_sof
      |=> ~dec.deliver
          & (st.sof_overrun_counter == $past(st.sof_overrun_counter) + `RFF_CNT_ONE);
  endproperty
  a_sof_drop: assert property (p_sof_drop)
    else $error("start overrun not dropped and counted");

  property p_mof_no_err;
    frame_done & ~frame.sof_ovr & frame.mof_ovr & ~st.error_frame_enable
      & (frame.len < st.rx_max_length) |=> ~dec.deliver;
  endproperty
  a_mof_no_err: assert property (p_mof_no_err)
    else $error("middle overrun delivered with error enable clear");

  property p_mof_match;
    frame_done & ~frame.sof_ovr & frame.mof_ovr & st.error_frame_enable
      & frame.addr_hit & frame.chan_en & frame.match_or_filter_bit & ~frame.ctrl
      & (frame.len < st.rx_max_length)
      |=> dec.deliver & dec.overrun & ~dec.no_match_flag
          & (dec.chan == $past(frame.hit_chan));
  endproperty
  a_mof_match: assert property (p_mof_match)
    else $error("matching middle overrun not delivered with overrun flag");

  property p_max_len;
    frame_done & (frame.len >= st.rx_max_length) |=> ~dec.overrun;
  endproperty
  a_max_len: assert property (p_max_len)
    else $error("frame at maximum length reported as overrun");

  property p_mof_count;
    frame_done & ~frame.sof_ovr & frame.mof_ovr & (frame.len < st.rx_max_length)
      & ~clr_mof
      |=> st.mof_overrun_counter == $past(st.mof_overrun_counter) + `RFF_CNT_ONE;
  endproperty
  a_mof_count: assert property (p_mof_count)
    else $error("middle overrun counter did not advance");

  property p_disabled_chan;
    frame_done & frame.addr_hit & ~frame.chan_en |=> ~dec.deliver | dec.no_match_flag;
  endproperty
  a_disabled_chan: assert property (p_disabled_chan)
    else $error("hit on disabled channel treated as match");

  property p_ctrl_match;
    frame_done & frame.ctrl & ~st.control_frame_enable |=> ~dec.deliver | dec.no_match_flag;
  endproperty
  a_ctrl_match: assert property (p_ctrl_match)
    else $error("control frame matched with control enable clear");

  property p_err_match;
    clean_in & frame.addr_hit & frame.chan_en & frame.match_or_filter_bit & ~frame.ctrl
      & in_err & in_mid & st.accept_all_enable & st.error_frame_enable
      |=> dec.deliver & ~dec.no_match_flag & (dec.chan == $past(frame.hit_chan));
  endproperty
  a_err_match: assert property (p_err_match)
    else $error("errored matching frame not sent to its channel");

  property p_prom_chan;
    frame_done & ~frame.addr_hit
      |=> ~dec.deliver | (dec.chan == $past(st.promiscuous_channel_select));
  endproperty
  a_prom_chan: assert property (p_prom_chan)
    else $error("non-matching frame sent off the promiscuous channel");

  property p_err_gate;
    clean_in & in_err & ~st.error_frame_enable |=> ~dec.deliver;
  endproperty
  a_err_gate: assert property (p_err_gate)
    else $error("errored frame delivered with error enable clear");

  property p_frag_gate;
    clean_in & in_err & (frame.len < `RFF_MIN_LEN)
      & ~(st.error_frame_enable & st.short_frame_enable) |=> ~dec.deliver;
  endproperty
  a_frag_gate: assert property (p_frag_gate)
    else $error("fragment delivered without error and short enables");

  property p_frag_take;
    clean_in & ~frame.addr_hit & ~frame.ctrl & in_err & (frame.len < `RFF_MIN_LEN)
      & st.accept_all_enable & st.error_frame_enable & st.short_frame_enable
      |=> dec.deliver & dec.no_match_flag;
  endproperty
  a_frag_take: assert property (p_frag_take)
    else $error("fragment not delivered with error and short enables");

  property p_all_prom;
    clean_in & ~frame.addr_hit & st.accept_all_enable & st.error_frame_enable
      & st.control_frame_enable & st.short_frame_enable |=> dec.deliver & dec.no_match_flag;
  endproperty
  a_all_prom: assert property (p_all_prom)
    else $error("non-matching frame dropped with all enables set");

  property p_all_match;
    clean_in & frame.addr_hit & frame.chan_en & frame.match_or_filter_bit
      & st.error_frame_enable & st.control_frame_enable & st.short_frame_enable
      |=> dec.deliver & ~dec.no_match_flag & (dec.chan == $past(frame.hit_chan));
  endproperty
  a_all_match: assert property (p_all_match)
    else $error("matching frame dropped with all class enables set");

  property p_prom_mof;
    frame_done & ~frame.sof_ovr & frame.mof_ovr & (frame.len < st.rx_max_length)
      & ~frame.addr_hit & st.accept_all_enable & st.error_frame_enable
      |=> dec.deliver & dec.overrun & dec.no_match_flag
          & (dec.chan == $past(st.promiscuous_channel_select));
  endproperty
  a_prom_mof: assert property (p_prom_mof)
    else $error("promiscuous middle overrun not delivered with flags");

  property p_long_class;
    frame_done & (frame.len > st.rx_max_length) & (frame.len >= `RFF_MIN_LEN)
      |=> dec.truncate & (dec.cls == ($past(in_err) ? RFF_JABBER : RFF_OVER));
  endproperty
  a_long_class: assert property (p_long_class)
    else $error("long frame not classed oversize or jabber");

  property p_short_class;
    frame_done & (frame.len < `RFF_MIN_LEN)
      |=> dec.cls == ($past(in_err) ? RFF_FRAG : RFF_UNDER);
  endproperty
  a_short_class: assert property (p_short_class)
    else $error("short frame not classed undersized or fragment");

  property p_proper_class;
    frame_done & ~in_err & in_mid & ~frame.mof_ovr |=> dec.cls == RFF_PROPER;
  endproperty
  a_proper_class: assert property (p_proper_class)
    else $error("clean frame in range not classed proper");

  property p_match_no_prom;
    clean_in & frame.addr_hit & frame.chan_en & frame.match_or_filter_bit & ~frame.ctrl
      & ~in_err & in_mid & ~st.accept_all_enable
      |=> dec.deliver & (dec.chan == $past(frame.hit_chan));
  endproperty
  a_match_no_prom: assert property (p_match_no_prom)
    else $error("proper matching frame depends on accept-all");

  property p_dma_count;
    frame_done & frame.sof_ovr & frame.ovr_dma & ~clr_dma
      |=> st.dma_overrun_counter == $past(st.dma_overrun_counter) + `RFF_CNT_ONE;
  endproperty
  a_dma_count: assert property (p_dma_count)
    else $error("dma overrun counter did not advance");

  c_prom_deliver: cover property (dec.deliver & dec.no_match_flag);
  c_match_overrun: cover property (dec.deliver & dec.overrun & ~dec.no_match_flag);
  c_sof_drop: cover property (frame_done & frame.sof_ovr ##1 ~dec.deliver);
  c_truncate: cover property (dec.deliver & dec.truncate);
  c_frag_deliver: cover property (dec.deliver & (dec.cls == RFF_FRAG));

endmodule

// file: include/rff_regs.svh
`ifndef RFF_REGS_SVH
`define RFF_REGS_SVH

// ==========================================
// Register offsets
`define RFF_ADDR_FILTER_EN 8'h00
`define RFF_ADDR_MAX_LEN   8'h04
`define RFF_ADDR_SOF_CNT   8'h08
`define RFF_ADDR_MOF_CNT   8'h0C
`define RFF_ADDR_DMA_CNT   8'h10
`define RFF_ADDR_LAST      8'h14

// ==========================================
// Field positions of the filter enable register
`define RFF_BIT_ACCEPT_ALL 0
`define RFF_BIT_ERROR      1
`define RFF_BIT_CONTROL    2
`define RFF_BIT_SHORT      3
`define RFF_CHAN_LSB       4
`define RFF_CHAN_MSB       6

// ==========================================
// Reset values and frame lengths
`define RFF_MAX_LEN_RST    16'h05EE
`define RFF_MIN_LEN        16'h0040
`define RFF_CNT_RST        32'h0000_0000
`define RFF_CNT_ONE        32'h0000_0001

`endif

// file: include/rff_pkg.sv
package rff_pkg;

  // ==========================================
  // Frame classes
  typedef enum logic [5:0] {
    RFF_PROPER  = 6'h01,
    RFF_UNDER   = 6'h02,
    RFF_FRAG    = 6'h04,
    RFF_OVER    = 6'h08,
    RFF_JABBER  = 6'h10,
    RFF_ERRORED = 6'h20
  } rff_class_e;

  // ==========================================
  // Per-frame report from the receive path
  typedef struct packed {
    logic [15:0] len;
    logic        crc_err;
    logic        code_err;
    logic        align_err;
    logic        ctrl;
    logic        addr_hit;
    logic        chan_en;
    logic        match_or_filter_bit;
    logic [2:0]  hit_chan;
    logic        sof_ovr;
    logic        mof_ovr;
    logic        ovr_dma;
  } rff_frame_s;

  // ==========================================
  // Decision handed to the receive DMA
  typedef struct packed {
    logic       valid;
    logic       deliver;
    logic [2:0] chan;
    logic       overrun;
    logic       no_match_flag;
    logic       truncate;
    rff_class_e cls;
  } rff_dec_s;

  // ==========================================
  // Whole module state
  typedef struct packed {
    logic        accept_all_enable;
    logic        error_frame_enable;
    logic        control_frame_enable;
    logic        short_frame_enable;
    logic [2:0]  promiscuous_channel_select;
    logic [15:0] rx_max_length;
    logic [31:0] sof_overrun_counter;
    logic [31:0] mof_overrun_counter;
    logic [31:0] dma_overrun_counter;
    rff_dec_s    dec;
    logic [31:0] rdata;
  } rff_state_s;

endpackage

// file: testbench/rff_rx_source.sv
`timescale 1ns/1ps
// ==========================================
// Receive path model: one frame report per send request
module rff_rx_source
  import rff_pkg::*;
(
  // Clock
  input  wire logic       core_clk,
  // Request from the bench
  input  wire logic       send,
  input  wire rff_frame_s fin,
  // Report to the filter
  output logic            frame_done,
  output rff_frame_s      frame
);
  // Report lasts one cycle; between reports the bus shows the inverse of the last one
  always_ff @(posedge core_clk) begin
    frame_done <= send;
    frame      <= send ? fin : ~fin;
  end
endmodule

// file: testbench/tb_rff_filter.sv
`timescale 1ns/1ps
`include "rff_regs.svh"
// ==========================================
// Bench for the receive frame filter
module tb_rff_filter;
  import rff_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        send;
  rff_frame_s  fin;
  logic        frame_done;
  rff_frame_s  frame;
  rff_dec_s    dec;
  logic [3:0]  en;
  logic [2:0]  pch;
  logic [15:0] maxl;
  logic [31:0] cnt [3];
  int          miscompares = 0;
  int          total_checks = 0;

  rff_rx_source i_rff_rx_source (.core_clk(core_clk), .send(send), .fin(fin),
                                 .frame_done(frame_done), .frame(frame));
  rff_filter i_rff_filter (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr),
                           .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
                           .reg_rdata(reg_rdata), .frame_done(frame_done), .frame(frame),
                           .dec(dec));

  always #2 core_clk = ~core_clk;

  // ==========================================
  // Compare and verdict
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    if (miscompares == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================
  // Register port cycles
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask

  // ==========================================
  // Frame table entry k
  function automatic rff_frame_s mk(input logic [8:0] k);
    rff_frame_s f;
    f = '0;
    case (k[1:0])
      2'h0:    f.len = `RFF_MIN_LEN - 16'h0001;
      2'h1:    f.len = `RFF_MIN_LEN;
      2'h2:    f.len = maxl;
      default: f.len = maxl + 16'h0001;
    endcase
    f.crc_err             = k[2] & k[4];
    f.code_err            = k[2] & !k[4] & k[6];
    f.align_err           = k[2] & !k[4] & !k[6];
    f.ctrl                = k[3];
    f.addr_hit            = k[5] | k[4];
    f.chan_en             = k[5];
    f.match_or_filter_bit = k[4];
    f.hit_chan            = k[2:0] ^ 3'h5;
    f.sof_ovr             = k[6];
    f.mof_ovr             = k[7];
    f.ovr_dma             = k[8];
    return f;
  endfunction

  // ==========================================
  // Send one report and check the decision
  task frame_check(input rff_frame_s f);
    logic       err;
    logic       lng;
    logic       mof;
    logic       m;
    logic       filt;
    logic       ok;
    logic       dl;
    rff_class_e c;
    err  = f.crc_err | f.code_err | f.align_err;
    mof  = f.mof_ovr & !f.sof_ovr & (f.len < maxl);
    lng  = (f.len > maxl) | (f.mof_ovr & (f.len >= maxl));
    c    = lng ? (err ? RFF_JABBER : RFF_OVER) :
           (f.len < `RFF_MIN_LEN) ? (err ? RFF_FRAG : RFF_UNDER) :
           (err ? RFF_ERRORED : RFF_PROPER);
    m    = f.addr_hit & f.chan_en & f.match_or_filter_bit & (!f.ctrl | en[2]);
    filt = f.addr_hit & f.chan_en & !f.match_or_filter_bit;
    ok   = (c == RFF_PROPER) | ((c == RFF_UNDER) & en[3]) | ((c == RFF_FRAG) & en[1] & en[3])
         | (((c == RFF_OVER) | (c == RFF_JABBER) | (c == RFF_ERRORED)) & en[1]);
    if (f.sof_ovr) begin
      dl = 1'b0;
    end else if (mof) begin
      dl = !filt & (m | en[0]) & en[1];
    end else begin
      dl = !filt & (m | en[0]) & ok & (!f.ctrl | en[2]);
    end
    cnt[0] = cnt[0] + 32'(f.sof_ovr);
    cnt[1] = cnt[1] + 32'(mof);
    cnt[2] = cnt[2] + 32'((f.sof_ovr | mof) & f.ovr_dma);
    @(posedge core_clk);
    send <= 1'b1;
    fin  <= f;
    @(posedge core_clk);
    send <= 1'b0;
    @(posedge core_clk);
    #1;
    check(dec.valid, 1'b1);
    check(dec.deliver, dl);
    check(dec.cls, c);
    check(dec.truncate, lng);
    if (dl) begin
      check(dec.chan, m ? f.hit_chan : pch);
      check(dec.no_match_flag, !m);
      check(dec.overrun, mof);
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    srst      = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    send      = 1'b0;
    fin       = '0;
    cnt       = '{32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd(`RFF_ADDR_FILTER_EN, 32'h0000_0000);
    rd(`RFF_ADDR_MAX_LEN, 32'h0000_05EE);
    rd(8'h18, 32'h0000_0000);
    rd(`RFF_ADDR_LAST, 32'h0000_0001);
    maxl = 16'h0064;
    wr(`RFF_ADDR_MAX_LEN, {16'h0000, maxl});
    rd(`RFF_ADDR_MAX_LEN, {16'h0000, maxl});
    for (int e = 0; e < 16; e++) begin
      en  = e[3:0];
      pch = e[2:0] ^ 3'h3;
      wr(`RFF_ADDR_FILTER_EN, {25'h0, pch, en});
      rd(`RFF_ADDR_FILTER_EN, {25'h0, pch, en});
      for (int k = 0; k < 512; k++) begin
        frame_check(mk(k[8:0]));
      end
      for (int i = 0; i < 3; i++) begin
        rd(`RFF_ADDR_SOF_CNT + 8'(4 * i), cnt[i]);
        wr(`RFF_ADDR_SOF_CNT + 8'(4 * i), 32'h0000_0000);
        cnt[i] = 32'h0;
      end
    end
    report_and_stop;
  end

  // ==========================================
  // Watchdog
  initial begin
    repeat (40000) @(posedge core_clk);
    miscompares++;
    report_and_stop;
  end
endmodule
